// *** design/atr_alert_targets.sv ***
// alert target registers with per-channel window and threshold compare
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// one compare channel
// ------------------------------------------------------------
module atr_chan #(
	parameter int W = 16
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         en_i,
	// sample and setup
	input  wire logic         signed_i,
	input  wire logic         valid_i,
	input  wire logic [W-1:0] sample_i,
	input  wire logic [W-1:0] target_i,
	input  wire logic [W-1:0] window_i,
	// results
	output logic              near_o,
	output logic              cross_o
);
	// two guard bits so t+w and t-w never wrap in either mode
	logic signed [W+1:0] s_ext;
	logic signed [W+1:0] t_ext;
	logic signed [W+1:0] w_ext;
	logic signed [W+1:0] hi_th;
	logic signed [W+1:0] lo_th;
	logic                win_nz;
	logic                near_now;
	logic [2:0]          side_now;
	logic                crossed;
	logic [2:0]          side_q;
	logic                seen_q;

	assign s_ext = signed_i ? {{2{sample_i[W-1]}}, sample_i}
	                        : {2'b00, sample_i};
	assign t_ext = signed_i ? {{2{target_i[W-1]}}, target_i}
	                        : {2'b00, target_i};
	assign w_ext = {2'b00, window_i};
	assign hi_th = t_ext + w_ext;
	assign lo_th = t_ext - w_ext;
	assign win_nz = |window_i;
	assign near_now = (s_ext >= lo_th) && (s_ext <= hi_th) && win_nz;
	assign side_now = {s_ext > hi_th, s_ext >= t_ext, s_ext >= lo_th};
	assign crossed = seen_q && ((side_q[1] != side_now[1]) ||
		(win_nz && ((side_q[2] != side_now[2]) ||
		            (side_q[0] != side_now[0]))));

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			near_o  <= 1'b0;
			cross_o <= 1'b0;
			side_q  <= 3'b000;
			seen_q  <= 1'b0;
		end else if (en_i) begin
			cross_o <= valid_i & crossed;
			if (valid_i) begin
				near_o <= near_now;
				side_q <= side_now;
				seen_q <= 1'b1;
			end
		end
	end
endmodule : atr_chan

// ------------------------------------------------------------
// top: register bank plus two channels
// ------------------------------------------------------------
module atr_alert_targets (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  en_i,
	// register access
	input  wire atr_pkg::atr_reg_req_t req_i,
	output logic [7:0]                 rdata_o,
	output logic                       rhit_o,
	// setup from neighbouring registers
	input  wire logic                  altimeter_mode_select_i,
	input  wire logic [15:0]           pressure_window_i,
	input  wire logic [7:0]            temperature_window_value_i,
	// samples
	input  wire atr_pkg::atr_pres_smp_t pres_i,
	input  wire atr_pkg::atr_temp_smp_t temp_i,
	// alert results
	output logic                       pressure_window_alert_flag_o,
	output logic                       temperature_window_alert_flag_o,
	output logic                       pressure_threshold_flag_o,
	output logic                       temperature_threshold_flag_o,
	// targets as seen by the compare logic
	output logic [15:0]                pressure_target_value_o,
	output logic [7:0]                 temperature_target_value_o
);
	logic [7:0] ptgt_high_q;
	logic [7:0] ptgt_low_q;
	logic [7:0] ttgt_q;
	logic       sel_high;
	logic       sel_low;
	logic       sel_temp;
	logic       hit;
	logic [7:0] rmux;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	assign sel_high = req_i.addr == atr_pkg::ADDR_PTGT_HIGH;
	assign sel_low  = req_i.addr == atr_pkg::ADDR_PTGT_LOW;
	assign sel_temp = req_i.addr == atr_pkg::ADDR_TTGT;
	assign hit  = sel_high | sel_low | sel_temp;
	assign rmux = sel_high ? ptgt_high_q :
	              sel_low  ? ptgt_low_q  :
	              sel_temp ? ttgt_q      : atr_pkg::UNMAPPED_BYTE;
	assign pressure_target_value_o    = {ptgt_high_q, ptgt_low_q};
	assign temperature_target_value_o = ttgt_q;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// bytes update one at a time; a compare between the two writes
	// sees a half-new target, so software should write while idle
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ptgt_high_q <= atr_pkg::RESET_BYTE;
			ptgt_low_q  <= atr_pkg::RESET_BYTE;
			ttgt_q      <= atr_pkg::RESET_BYTE;
			rdata_o     <= atr_pkg::RESET_BYTE;
			rhit_o      <= 1'b0;
		end else if (en_i) begin
			if (req_i.wr && sel_high) ptgt_high_q <= req_i.wdata;
			if (req_i.wr && sel_low)  ptgt_low_q  <= req_i.wdata;
			if (req_i.wr && sel_temp) ttgt_q      <= req_i.wdata;
			if (req_i.rd) begin
				rdata_o <= rmux;
				rhit_o  <= hit;
			end
		end
	end

	// ------------------------------------------------------------
	// compare channels
	// ------------------------------------------------------------
	atr_chan #(.W(atr_pkg::PRES_W)) u_pres (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.en_i     (en_i),
		.signed_i (altimeter_mode_select_i),
		.valid_i  (pres_i.valid),
		.sample_i (pres_i.value),
		.target_i ({ptgt_high_q, ptgt_low_q}),
		.window_i (pressure_window_i),
		.near_o   (pressure_window_alert_flag_o),
		.cross_o  (pressure_threshold_flag_o)
	);

	atr_chan #(.W(atr_pkg::TEMP_W)) u_temp (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.en_i     (en_i),
		.signed_i (1'b1),
		.valid_i  (temp_i.valid),
		.sample_i (temp_i.value),
		.target_i (ttgt_q),
		.window_i (temperature_window_value_i),
		.near_o   (temperature_window_alert_flag_o),
		.cross_o  (temperature_threshold_flag_o)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_wr_high;
		@(posedge clk_i) disable iff (!resetn_i)
		(en_i && req_i.wr && sel_high) |=> ptgt_high_q == $past(req_i.wdata);
	endproperty
	a_wr_high: assert property (p_wr_high) else $error("high byte lost");

	property p_rd_low;
		@(posedge clk_i) disable iff (!resetn_i)
		(en_i && req_i.rd && sel_low && !req_i.wr)
		|=> rdata_o == ptgt_low_q && rhit_o;
	endproperty
	a_rd_low: assert property (p_rd_low) else $error("low byte misread");

	property p_rd_temp;
		@(posedge clk_i) disable iff (!resetn_i)
		(en_i && req_i.rd && sel_temp && !req_i.wr) |=> rdata_o == ttgt_q;
	endproperty
	a_rd_temp: assert property (p_rd_temp) else $error("temp misread");

	property p_unmapped;
		@(posedge clk_i) disable iff (!resetn_i)
		(en_i && req_i.rd && !hit)
		|=> rdata_o == atr_pkg::UNMAPPED_BYTE && !rhit_o;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped data");

	property p_zero_win;
		@(posedge clk_i) disable iff (!resetn_i)
		(en_i && temp_i.valid && temperature_window_value_i == 8'h00)
		|=> !temperature_window_alert_flag_o;
	endproperty
	a_zero_win: assert property (p_zero_win) else $error("flag w/o window");

	property p_altitude_signed;
		@(posedge clk_i) disable iff (!resetn_i)
		(en_i && pres_i.valid && altimeter_mode_select_i &&
		 pres_i.value == 16'hFFFF && pressure_target_value_o == 16'h0001 &&
		 pressure_window_i == 16'h0002)
		|=> pressure_window_alert_flag_o;
	endproperty
	a_altitude_signed: assert property (p_altitude_signed)
		else $error("altitude sign");

	property p_bar_unsigned;
		@(posedge clk_i) disable iff (!resetn_i)
		(en_i && pres_i.valid && !altimeter_mode_select_i &&
		 pres_i.value == 16'hFFFF && pressure_target_value_o == 16'h0001 &&
		 pressure_window_i == 16'h0002)
		|=> !pressure_window_alert_flag_o;
	endproperty
	a_bar_unsigned: assert property (p_bar_unsigned) else $error("bar sign");

	property p_cross_cause;
		@(posedge clk_i) disable iff (!resetn_i)
		// a pulse caught by a low enable is frozen, not a stray event
		pressure_threshold_flag_o
		|-> ($past(en_i) && $past(pres_i.valid)) ||
		    (!$past(en_i) && $past(pressure_threshold_flag_o));
	endproperty
	a_cross_cause: assert property (p_cross_cause) else $error("stray cross");

	property p_cross_pulse;
		@(posedge clk_i) disable iff (!resetn_i)
		(temperature_threshold_flag_o && en_i && !temp_i.valid)
		|=> !temperature_threshold_flag_o;
	endproperty
	a_cross_pulse: assert property (p_cross_pulse) else $error("long pulse");

	c_pres_near: cover property (@(posedge clk_i)
		pressure_window_alert_flag_o);
	c_pres_cross: cover property (@(posedge clk_i)
		pressure_threshold_flag_o);
	c_temp_cross: cover property (@(posedge clk_i)
		temperature_threshold_flag_o);
	c_temp_near: cover property (@(posedge clk_i)
		temperature_window_alert_flag_o);
endmodule : atr_alert_targets

`default_nettype wire

// *** design/atr_pkg.sv ***
// constants and carrier types for the alert target register bank
`default_nettype none

package atr_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PTGT_HIGH = 8'h16;
	localparam logic [7:0] ADDR_PTGT_LOW  = 8'h17;
	localparam logic [7:0] ADDR_TTGT      = 8'h18;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [7:0] UNMAPPED_BYTE  = 8'h00;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int PRES_W = 16;
	localparam int TEMP_W = 8;
	localparam int BYTE_W = 8;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} atr_reg_req_t;

	typedef struct packed {
		logic              valid;
		logic [PRES_W-1:0] value;
	} atr_pres_smp_t;

	typedef struct packed {
		logic              valid;
		logic [TEMP_W-1:0] value;
	} atr_temp_smp_t;

endpackage : atr_pkg

`default_nettype wire

// *** tb/atr_host_model.sv ***
// host side model issuing register requests to the target bank
`timescale 1ns/1ps
`default_nettype none

module atr_host_model (
	// clock
	input  wire logic                 clk_i,
	// register port
	output var atr_pkg::atr_reg_req_t req_o,
	input  wire logic [7:0]           rdata_i,
	input  wire logic                 rhit_i
);
	// idle lines carry the inverted address, and after a write inverted data, so stale values never match
	initial req_o = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic h);
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
		#1;
		d = rdata_i;
		h = rhit_i;
	endtask : rd
endmodule : atr_host_model

`default_nettype wire

// *** tb/atr_alert_targets_tb_top.sv ***
// self-checking bench for the alert target register bank
`timescale 1ns/1ps
`default_nettype none

module atr_alert_targets_tb_top;
	// ------------------------------------------------------------
	// stimulus and observation
	// ------------------------------------------------------------
	logic                   clk_i    = 1'b0;
	logic                   resetn_i = 1'b0;
	logic                   en_i     = 1'b1;
	logic                   mode_sel = 1'b0;
	logic [15:0]            pwin     = 16'h0000;
	logic [7:0]             twin     = 8'h00;
	atr_pkg::atr_pres_smp_t pres     = '0;
	atr_pkg::atr_temp_smp_t temp     = '0;
	atr_pkg::atr_reg_req_t  req;
	logic [7:0]             rdata, rd_v, tgt8;
	logic [15:0]            ptgt;
	logic                   rhit, rd_h, pnear, tnear, pthr, tthr;
	int                     num_errors = 0;
	int                     n_checks   = 0;

	initial forever #25 clk_i = ~clk_i;

	atr_alert_targets atr_alert_targets_i (
		.clk_i(clk_i), .resetn_i(resetn_i), .en_i(en_i), .req_i(req),
		.rdata_o(rdata), .rhit_o(rhit), .altimeter_mode_select_i(mode_sel),
		.pressure_window_i(pwin), .temperature_window_value_i(twin),
		.pres_i(pres), .temp_i(temp),
		.pressure_window_alert_flag_o(pnear),
		.temperature_window_alert_flag_o(tnear),
		.pressure_threshold_flag_o(pthr),
		.temperature_threshold_flag_o(tthr),
		.pressure_target_value_o(ptgt), .temperature_target_value_o(tgt8));

	atr_host_model atr_host_model_i (
		.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rhit_i(rhit));

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task automatic cmp_bit(input string what, input logic exp, got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s exp %b got %b", what, exp, got);
		end
	endtask : cmp_bit

	task automatic cmp_val(input string what, input logic [15:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask : cmp_val

	task automatic chk_rd(input logic [7:0] a, exp, input logic hit);
		atr_host_model_i.rd(a, rd_v, rd_h);
		cmp_val("rdata", {8'h00, exp}, {8'h00, rd_v});
		cmp_bit("rhit", hit, rd_h);
	endtask : chk_rd

	// one sample; window flag judged after the taking edge
	task automatic smp(input logic t, m, input logic [15:0] v,
		input logic near);
		@(posedge clk_i);
		mode_sel <= m;
		if (t) temp <= '{valid: 1'b1, value: v[7:0]};
		else pres <= '{valid: 1'b1, value: v};
		@(posedge clk_i);
		temp <= '{valid: 1'b0, value: ~v[7:0]};
		pres <= '{valid: 1'b0, value: ~v};
		#1;
		cmp_bit("near", near, t ? tnear : pnear);
	endtask : smp

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		chk_rd(8'h16, 8'h00, 1'b1);
		chk_rd(8'h17, 8'h00, 1'b1);
		chk_rd(8'h18, 8'h00, 1'b1);
		chk_rd(8'h19, 8'h00, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_rw;
		atr_host_model_i.wr(8'h16, 8'hA5);
		atr_host_model_i.wr(8'h17, 8'h3C);
		atr_host_model_i.wr(8'h18, 8'hE7);
		#1;
		cmp_val("ptgt", 16'hA53C, ptgt);
		cmp_val("ttgt", 16'h00E7, {8'h00, tgt8});
		@(posedge clk_i);
		en_i <= 1'b0;
		atr_host_model_i.wr(8'h16, 8'h00);
		en_i <= 1'b1;
		chk_rd(8'h16, 8'hA5, 1'b1);
		chk_rd(8'h17, 8'h3C, 1'b1);
		chk_rd(8'h18, 8'hE7, 1'b1);
		$display("test readwrite done");
	endtask : t_rw

	// same bits: near as unsigned, far as signed
	task automatic t_mode;
		atr_host_model_i.wr(8'h16, 8'h7F);
		atr_host_model_i.wr(8'h17, 8'hF0);
		pwin <= 16'h0020;
		smp(1'b0, 1'b0, 16'h8000, 1'b1);
		smp(1'b0, 1'b1, 16'h8000, 1'b0);
		$display("test mode done");
	endtask : t_mode

	task automatic t_thr;
		atr_host_model_i.wr(8'h16, 8'h10);
		atr_host_model_i.wr(8'h17, 8'h00);
		pwin <= 16'h0000;
		smp(1'b0, 1'b0, 16'h0F00, 1'b0);
		smp(1'b0, 1'b0, 16'h1000, 1'b0);
		cmp_bit("pthr", 1'b1, pthr);
		@(posedge clk_i);
		#1;
		cmp_bit("pthr", 1'b0, pthr);
		@(posedge clk_i);
		pwin <= 16'h0100;
		smp(1'b0, 1'b0, 16'h1050, 1'b1);
		cmp_bit("pthr", 1'b0, pthr);
		smp(1'b0, 1'b0, 16'h1200, 1'b0);
		cmp_bit("pthr", 1'b1, pthr);
		$display("test threshold done");
	endtask : t_thr

	task automatic t_temp;
		atr_host_model_i.wr(8'h18, 8'h05);
		twin <= 8'h08;
		smp(1'b1, 1'b0, 16'h00FE, 1'b1);
		smp(1'b1, 1'b0, 16'h0007, 1'b1);
		cmp_bit("tthr", 1'b1, tthr);
		atr_host_model_i.wr(8'h18, 8'hF0);
		smp(1'b1, 1'b0, 16'h00EE, 1'b1);
		cmp_bit("tthr", 1'b1, tthr);
		$display("test temperature done");
	endtask : t_temp

	// sign corner, zero window, unmapped write, reset in mid-run
	task automatic t_edge;
		atr_host_model_i.wr(8'h16, 8'h00);
		atr_host_model_i.wr(8'h17, 8'h01);
		pwin <= 16'h0002;
		smp(1'b0, 1'b1, 16'hFFFF, 1'b1);
		smp(1'b0, 1'b0, 16'hFFFF, 1'b0);
		twin <= 8'h00;
		smp(1'b1, 1'b0, 16'h00F0, 1'b0);
		cmp_bit("tthr", 1'b1, tthr);
		atr_host_model_i.wr(8'h19, 8'h77);
		#1;
		cmp_val("ptgt", 16'h0001, ptgt);
		cmp_val("ttgt", 16'h00F0, {8'h00, tgt8});
		@(posedge clk_i);
		resetn_i <= 1'b0;
		@(posedge clk_i);
		resetn_i <= 1'b1;
		#1;
		cmp_val("ptgt", 16'h0000, ptgt);
		cmp_val("ttgt", 16'h0000, {8'h00, tgt8});
		chk_rd(8'h17, 8'h00, 1'b1);
		$display("test edge done");
	endtask : t_edge

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_rw();
		t_mode();
		t_thr();
		t_temp();
		t_edge();
		final_report();
	end

	// tests need about 80 cycles
	initial begin
		repeat (2000) @(posedge clk_i);
		num_errors++;
		final_report();
	end
endmodule : atr_alert_targets_tb_top

`default_nettype wire
